// >>> hdl/ntsc_pkg.sv
/*
 constants for the no-turnaround sram controller.
 assumes a 64K x 36 synchronous sram with late (flowthrough) or late-late (pipelined) data.
*/
package ntsc_pkg;
	localparam int DATA_W = 36; // data bus width
	localparam int ADDR_W = 16; // 64K words
	localparam int PIPE_LAT = 2; // late-late data
	localparam int FLOW_LAT = 1; // late data
	localparam int OE_GROUP_W = 9; // bits per enable register
	localparam int REQ_FIFO_AW = 2; // request fifo, 4 entries
	localparam int RESP_FIFO_AW = 1; // read buffer, 2 entries
	localparam int PIPE_MEM_MHZ = 200; // pipelined memory clock
	localparam int FLOW_MEM_MHZ = 100; // flowthrough memory clock
	localparam int REF_CLK_MHZ = 25; // user side clock
	localparam logic WE_N_WRITE = 1'b0; // select level for write
	localparam logic WE_N_READ = 1'b1; // select level for read and idle
	localparam logic OE_N_ON = 1'b0; // memory output enable held on
	localparam logic CE_N_ON = 1'b0; // chip enable active level
endpackage

// >>> hdl/ntsc_sram_ctrl.sv
/*
 user-side request port, clock crossing fifos and the sram pin sequencer.
 assumes mem_clk_in comes from the clock_deskew_doubler loop and is the same
 clock that the board loop delivers to the memory; dq pins are synchronous to it.
*/
// dual clock fifo with gray-coded pointers
module ntsc_afifo #(
	parameter int W = 8,
	parameter int AW = 1
) (
	input wire logic wr_clk_in,
	input wire logic wr_rst_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	input wire logic [W-1:0] wr_data_in,
	output logic [AW:0] wr_level_out,
	input wire logic rd_clk_in,
	input wire logic rd_rst_in,
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output logic [W-1:0] rd_data_out
);
	logic [W-1:0] mem [0:(1<<AW)-1]; // storage
	logic [AW:0] wbin; // write pointer, binary
	logic [AW:0] wgray; // write pointer, gray
	logic [AW:0] rbin; // read pointer, binary
	logic [AW:0] rgray; // read pointer, gray
	logic [AW:0] rg_s1; // read pointer sync, first stage
	logic [AW:0] rg_s2; // read pointer sync, second stage
	logic [AW:0] wg_s1; // write pointer sync, first stage
	logic [AW:0] wg_s2; // write pointer sync, second stage

	function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
		logic [AW:0] b;
		b = g;
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	wire wr_fire = wr_valid_in && wr_ready_out;
	wire rd_fire = rd_valid_out && rd_ready_in;
	wire [AW:0] next_wbin = wbin + {{AW{1'b0}}, wr_fire};
	wire [AW:0] next_rbin = rbin + {{AW{1'b0}}, rd_fire};
	// level may lag a pop by the sync delay, never a push: full is safe
	assign wr_level_out = wbin - gray2bin(rg_s2);
	assign wr_ready_out = !wr_level_out[AW];
	assign rd_valid_out = (rgray != wg_s2);
	assign rd_data_out = mem[rbin[AW-1:0]];

	// storage write, no reset needed on data
	always_ff @(posedge wr_clk_in) begin
		if (wr_fire) begin
			mem[wbin[AW-1:0]] <= wr_data_in;
		end
	end

	// write side pointers and read pointer sync
	always_ff @(posedge wr_clk_in) begin
		if (wr_rst_in) begin
			wbin <= '0;
			wgray <= '0;
			rg_s1 <= '0;
			rg_s2 <= '0;
		end else begin
			wbin <= next_wbin;
			wgray <= bin2gray(next_wbin);
			rg_s1 <= rgray;
			rg_s2 <= rg_s1;
		end
	end

	// read side pointers and write pointer sync
	always_ff @(posedge rd_clk_in) begin
		if (rd_rst_in) begin
			rbin <= '0;
			rgray <= '0;
			wg_s1 <= '0;
			wg_s2 <= '0;
		end else begin
			rbin <= next_rbin;
			rgray <= bin2gray(next_rbin);
			wg_s1 <= wgray;
			wg_s2 <= wg_s1;
		end
	end
endmodule

// controller top
module ntsc_sram_ctrl #(
	parameter bit PIPELINED = 1'b1,
	parameter int BANK_W = 1,
	parameter int REQ_AW = ntsc_pkg::REQ_FIFO_AW,
	parameter int RESP_AW = ntsc_pkg::RESP_FIFO_AW
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic req_write_in,
	input wire logic [BANK_W-1:0] req_bank_in,
	input wire logic [ntsc_pkg::ADDR_W-1:0] req_addr_in,
	input wire logic [ntsc_pkg::DATA_W-1:0] req_data_in,
	output logic rsp_valid_out,
	input wire logic rsp_ready_in,
	output logic [ntsc_pkg::DATA_W-1:0] rsp_data_out,
	input wire logic mem_clk_in,
	output logic sram_clk_out,
	output logic [ntsc_pkg::ADDR_W-1:0] sram_addr_out,
	output logic sram_we_n_out,
	output logic [(1<<BANK_W)-1:0] sram_ce_n_out,
	output logic sram_oe_n_out,
	input wire logic [ntsc_pkg::DATA_W-1:0] sram_dq_in,
	output logic [ntsc_pkg::DATA_W-1:0] sram_dq_out,
	output logic [ntsc_pkg::DATA_W-1:0] sram_dq_oe_n_out
);
	localparam int DW = ntsc_pkg::DATA_W;
	localparam int AW = ntsc_pkg::ADDR_W;
	localparam int LAT = PIPELINED ? ntsc_pkg::PIPE_LAT : ntsc_pkg::FLOW_LAT;
	localparam int RLAT = LAT + 1; // pins to captured read word
	localparam int NG = DW / ntsc_pkg::OE_GROUP_W; // enable registers
	localparam int RQ_W = 1 + BANK_W + AW + DW; // request word
	localparam int NB = 1 << BANK_W;

	// refuse shapes that the pin logic cannot serve
	if (DW % ntsc_pkg::OE_GROUP_W != 0) begin : g_chk_grp
		$error("data width must split into enable groups");
	end
	if (AW != 16 || DW != 36) begin : g_chk_org
		$error("organisation must be 64K x 36");
	end
	if (BANK_W < 1 || RESP_AW < 1 || REQ_AW < 1) begin : g_chk_par
		$error("bank and fifo widths must be at least one");
	end

	logic mrst_s1; // reset sync, first stage
	logic mrst; // reset in the memory domain
	logic cmd_valid; // request waiting in memory domain
	logic [RQ_W-1:0] cmd_word; // request fields
	logic [RESP_AW:0] resp_level; // read buffer fill, as seen here
	logic [RESP_AW:0] outstanding; // reads issued, not yet pushed
	logic [AW-1:0] addr_q; // address pins
	logic we_n_q; // read/write select pin
	logic [NB-1:0] ce_n_q; // chip enables
	logic [DW-1:0] wd [0:LAT]; // write data delay line
	logic wr_s [0:LAT]; // internal write flag delay line
	logic rd_s [0:LAT]; // internal read flag delay line
	logic [NG-1:0] oe_grp; // replicated drive enables
	logic cap_valid; // captured read word ready to push
	logic [DW-1:0] cap_data; // captured read word
	logic issue; // request leaves the queue this cycle

	// the board loop and controller loop share one doubled source
	assign sram_clk_out = mem_clk_in;
	assign sram_oe_n_out = ntsc_pkg::OE_N_ON;

	// reset crosses as a level
	always_ff @(posedge mem_clk_in) begin
		mrst_s1 <= rst_in;
		mrst <= mrst_s1;
	end

	// data travels in the same word as address and select
	ntsc_afifo #(.W(RQ_W), .AW(REQ_AW)) u_req (
		.wr_clk_in(ref_clk_in),
		.wr_rst_in(rst_in),
		.wr_valid_in(req_valid_in),
		.wr_ready_out(req_ready_out),
		.wr_data_in({req_write_in, req_bank_in, req_addr_in, req_data_in}),
		.wr_level_out(),
		.rd_clk_in(mem_clk_in),
		.rd_rst_in(mrst),
		.rd_valid_out(cmd_valid),
		.rd_ready_in(issue),
		.rd_data_out(cmd_word)
	);

	wire cmd_write = cmd_word[RQ_W-1];
	wire [BANK_W-1:0] cmd_bank = cmd_word[AW+DW +: BANK_W];
	wire [AW-1:0] cmd_addr = cmd_word[DW +: AW];
	wire [DW-1:0] cmd_data = cmd_word[DW-1:0];
	// a read may go only if its word is sure of a buffer slot
	wire [RESP_AW+1:0] committed = {1'b0, resp_level} + {1'b0, outstanding};
	wire credit_ok = committed < (RESP_AW+2)'(1 << RESP_AW);
	// writes never wait, so a write follows a read in the next cycle
	assign issue = cmd_valid && (cmd_write || credit_ok);
	wire issue_rd = issue && !cmd_write;
	wire [NB-1:0] bank_sel = ~(NB'(1) << cmd_bank);
	wire [RESP_AW:0] next_outstanding = outstanding + {{RESP_AW{1'b0}}, issue_rd}
		- {{RESP_AW{1'b0}}, cap_valid};

	// address and select go to the pins with no extra stage
	always_ff @(posedge mem_clk_in) begin
		if (mrst) begin
			addr_q <= '0;
			we_n_q <= ntsc_pkg::WE_N_READ;
			// only bank 0 is selected, so idle dummy reads never let two chips fight on dq
			ce_n_q <= {{(NB-1){~ntsc_pkg::CE_N_ON}}, ntsc_pkg::CE_N_ON};
			wd[0] <= '0;
			wr_s[0] <= 1'b0;
			rd_s[0] <= 1'b0;
		end else begin
			wd[0] <= cmd_data;
			wr_s[0] <= issue && cmd_write;
			rd_s[0] <= issue_rd;
			if (issue) begin
				addr_q <= cmd_addr;
				we_n_q <= cmd_write ? ntsc_pkg::WE_N_WRITE : ntsc_pkg::WE_N_READ;
				ce_n_q <= bank_sel;
			end else begin
				// idle is a dummy read whose word is dropped
				we_n_q <= ntsc_pkg::WE_N_READ;
			end
		end
	end

	// data and internal flags delayed to the memory's data latency
	for (genvar k = 1; k <= LAT; k++) begin : g_dly
		always_ff @(posedge mem_clk_in) begin
			if (mrst) begin
				wd[k] <= '0;
				wr_s[k] <= 1'b0;
				rd_s[k] <= 1'b0;
			end else begin
				wd[k] <= wd[k-1];
				wr_s[k] <= wr_s[k-1];
				rd_s[k] <= rd_s[k-1];
			end
		end
	end

	// one enable register per group keeps the select fan-out low
	for (genvar g = 0; g < NG; g++) begin : g_oe
		always_ff @(posedge mem_clk_in) begin
			if (mrst) begin
				oe_grp[g] <= 1'b0;
			end else begin
				oe_grp[g] <= wr_s[LAT-1];
			end
		end
		assign sram_dq_oe_n_out[g*ntsc_pkg::OE_GROUP_W +: ntsc_pkg::OE_GROUP_W] =
			{ntsc_pkg::OE_GROUP_W{~oe_grp[g]}};
	end

	// write data reaches the pins LAT cycles after its address
	assign sram_dq_out = wd[LAT];
	assign sram_addr_out = addr_q;
	assign sram_we_n_out = we_n_q;
	assign sram_ce_n_out = ce_n_q;

	// sample the bus in the cycle the memory drives it
	always_ff @(posedge mem_clk_in) begin
		if (mrst) begin
			cap_valid <= 1'b0;
			cap_data <= '0;
			outstanding <= '0;
		end else begin
			cap_valid <= rd_s[LAT];
			cap_data <= sram_dq_in;
			outstanding <= next_outstanding;
		end
	end

	// read words cross back; credit keeps the push from ever being refused
	ntsc_afifo #(.W(DW), .AW(RESP_AW)) u_rsp (
		.wr_clk_in(mem_clk_in),
		.wr_rst_in(mrst),
		.wr_valid_in(cap_valid),
		.wr_ready_out(),
		.wr_data_in(cap_data),
		.wr_level_out(resp_level),
		.rd_clk_in(ref_clk_in),
		.rd_rst_in(rst_in),
		.rd_valid_out(rsp_valid_out),
		.rd_ready_in(rsp_ready_in),
		.rd_data_out(rsp_data_out)
	);

	wire pin_wr = !sram_we_n_out && wr_s[0];
	wire pin_rd = sram_we_n_out && rd_s[0];

	// the synced reset is unknown for its first two edges; the raw reset keeps checks off until then
	a_write_no_wait: assert property (@(posedge mem_clk_in) disable iff (mrst || rst_in)
		(cmd_valid && cmd_write) |=> (!sram_we_n_out && wr_s[0]))
		else $error("write request was held back");
	if (PIPELINED) begin : g_a_pipe
		a_pipe_write_lat: assert property (@(posedge mem_clk_in) disable iff (mrst || rst_in)
			pin_wr |-> ##2 (sram_dq_oe_n_out == '0 && sram_dq_out == $past(wd[0], 2)))
			else $error("pipelined write data not two cycles after address");
	end else begin : g_a_flow
		a_flow_write_lat: assert property (@(posedge mem_clk_in) disable iff (mrst || rst_in)
			pin_wr |-> ##1 (sram_dq_oe_n_out == '0 && sram_dq_out == $past(wd[0], 1)))
			else $error("flowthrough write data not one cycle after address");
	end
	a_drive_cause: assert property (@(posedge mem_clk_in) disable iff (mrst || rst_in)
		(sram_dq_oe_n_out != '1) |-> $past(pin_wr, LAT))
		else $error("bus driven without a write one latency earlier");
	a_read_release: assert property (@(posedge mem_clk_in) disable iff (mrst || rst_in)
		pin_rd |-> ##LAT (sram_dq_oe_n_out == '1))
		else $error("bus driven during read data cycle");
	a_static_ctrl: assert property (@(posedge mem_clk_in) disable iff (mrst || rst_in)
		##1 ($stable(sram_oe_n_out) && sram_oe_n_out == ntsc_pkg::OE_N_ON))
		else $error("output enable moved");
	a_addr_direct: assert property (@(posedge mem_clk_in) disable iff (mrst || rst_in)
		issue |=> (sram_addr_out == $past(cmd_addr) && sram_we_n_out == !$past(cmd_write)))
		else $error("address or select not sent in the next cycle");
	a_read_return: assert property (@(posedge mem_clk_in) disable iff (mrst || rst_in)
		pin_rd |-> ##RLAT (cap_valid && cap_data == $past(sram_dq_in)))
		else $error("read word not captured at the fixed delay");
	a_enable_tree: assert property (@(posedge mem_clk_in) disable iff (mrst || rst_in)
		(oe_grp == '0) || (oe_grp == '1))
		else $error("enable registers disagree");
	a_credit_hold: assert property (@(posedge mem_clk_in) disable iff (mrst || rst_in)
		(committed <= (RESP_AW+2)'(1 << RESP_AW)))
		else $error("more reads in flight than buffer slots");
endmodule

// >>> verif/ntsc_sram_model.sv
/* partner: one synchronous no-turnaround sram, 64K x 36, data LAT cycles after address.
 assumes the bench resolves the shared dq wire from every party's enable. */
module ntsc_sram_model #(
	parameter int LAT = 2
) (
	input wire logic clk_in,
	input wire logic ce_n_in,
	input wire logic we_n_in,
	input wire logic [15:0] addr_in,
	input wire logic [35:0] wdata_in,
	input wire logic [35:0] oe_n_in,
	output logic [35:0] rdata_out,
	output logic drive_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [35:0] mem [65536]; // cells, 64K words
	logic sel [LAT]; // op aimed at this chip
	logic wr [LAT]; // op was a write, from we_n alone
	logic [15:0] adr [LAT]; // op address
	// ops age one stage a cycle, a new one every cycle
	always @(posedge clk_in) begin
		for (int k = LAT - 1; k > 0; k--) begin
			sel[k] <= sel[k - 1];
			wr[k] <= wr[k - 1];
			adr[k] <= adr[k - 1];
		end
		sel[0] <= !ce_n_in;
		wr[0] <= !we_n_in;
		adr[0] <= addr_in;
		// late write; bits the controller fails to drive are stored inverted
		if (sel[LAT - 1] && wr[LAT - 1]) begin
			mem[adr[LAT - 1]] <= wdata_in ^ oe_n_in;
		end
	end
	// read data in cycle LAT; contention spoils it, so it shows in readback
	assign drive_out = sel[LAT - 1] && !wr[LAT - 1];
	assign rdata_out = mem[adr[LAT - 1]] ^ ~oe_n_in;
endmodule

// >>> verif/ntsc_sram_ctrl_bench.sv
/* bench: one lane per memory variant, each a controller, two sram chips and a checker.
 assumes mem clock is free running and unrelated in phase to the user clock. */
module ntsc_lane #(
	parameter bit PIPE = 1'b1
) (
	input wire logic ref_clk_in,
	input wire logic mem_clk_in,
	input wire logic rst_in,
	output int fails_out,
	output int checks_out,
	output logic done_out
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LAT = PIPE ? ntsc_pkg::PIPE_LAT : ntsc_pkg::FLOW_LAT;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [0:0] req_bank = '0;
	logic [15:0] req_addr = '0;
	logic [35:0] req_data = '0;
	logic rsp_ready = 1'b0;
	logic stall = 1'b0; // holds the reader off
	logic req_ready, rsp_valid, sclk, we_n, oe_n, drv0, drv1;
	logic [1:0] ce_n;
	logic [15:0] addr;
	logic [35:0] rsp_data, wdata, oe_n_dq, q0, q1, dq;
	logic [35:0] last = '0; // last wire level, for a released bus
	logic [35:0] expq [$]; // expected read words, in order
	logic [35:0] refm [bit [16:0]]; // reference memory
	bit [16:0] keys [$]; // written locations
	bit [16:0] edge_keys [4] = '{17'h00000, 17'h0FFFF, 17'h10000, 17'h1FFFF};
	// released wire shows the inverse of its last level, so stale data never passes
	assign dq = drv0 ? q0 : drv1 ? q1 : (wdata & ~oe_n_dq) | (~last & oe_n_dq);
	always @(posedge mem_clk_in) last <= dq;
	ntsc_sram_ctrl #(.PIPELINED(PIPE)) i_ntsc_sram_ctrl (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.req_valid_in(req_valid), .req_ready_out(req_ready), .req_write_in(req_write), .req_bank_in(req_bank),
		.req_addr_in(req_addr), .req_data_in(req_data), .rsp_valid_out(rsp_valid), .rsp_ready_in(rsp_ready),
		.rsp_data_out(rsp_data), .mem_clk_in(mem_clk_in), .sram_clk_out(sclk), .sram_addr_out(addr),
		.sram_we_n_out(we_n), .sram_ce_n_out(ce_n), .sram_oe_n_out(oe_n), .sram_dq_in(dq),
		.sram_dq_out(wdata), .sram_dq_oe_n_out(oe_n_dq));
	ntsc_sram_model #(.LAT(LAT)) i_ntsc_sram_model_0 (.clk_in(sclk), .ce_n_in(ce_n[0]), .we_n_in(we_n),
		.addr_in(addr), .wdata_in(wdata), .oe_n_in(oe_n_dq), .rdata_out(q0), .drive_out(drv0));
	ntsc_sram_model #(.LAT(LAT)) i_ntsc_sram_model_1 (.clk_in(sclk), .ce_n_in(ce_n[1]), .we_n_in(we_n),
		.addr_in(addr), .wdata_in(wdata), .oe_n_in(oe_n_dq), .rdata_out(q1), .drive_out(drv1));
	// counts and reports one comparison
	task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
		checks_out++;
		if (got !== exp) begin
			fails_out++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one request, held until taken; the expected word is noted at once
	task automatic issue(input logic w, input bit [16:0] key);
		logic [35:0] d;
		int n;
		d = 36'({$urandom, $urandom});
		@(negedge ref_clk_in);
		req_valid <= 1'b1;
		req_write <= w;
		{req_bank, req_addr} <= key;
		req_data <= d;
		if (w) begin
			refm[key] = d;
			keys.push_back(key);
		end else expq.push_back(refm[key]);
		for (n = 0; n < 500 && req_ready !== 1'b1; n++) @(negedge ref_clk_in);
		if (n == 500) chk("req_ready", 36'h1, 36'(req_ready));
		@(posedge ref_clk_in);
	endtask
	// waits, bounded, until every noted read came back
	task automatic drain();
		@(negedge ref_clk_in) req_valid <= 1'b0;
		for (int n = 0; n < 3000 && expq.size() > 0; n++) @(negedge ref_clk_in);
		chk("reads left", 36'h0, 36'(expq.size()));
	endtask
	// reader: random stalls; a word offered with ready high is taken next edge
	always @(negedge ref_clk_in) begin
		rsp_ready = !stall && ($urandom % 3 != 0);
		if (rsp_valid === 1'b1 && rsp_ready) chk("rsp_data", expq.size() ? expq.pop_front() : 'x, rsp_data);
	end
	// output enable stays static; we_n and ce_n are the live controls; exactly one chip is ever selected
	always @(negedge mem_clk_in) if (!rst_in) begin
		chk("oe_n", 36'(ntsc_pkg::OE_N_ON), 36'(oe_n));
		chk("ce_n one hot", 36'h1, 36'(ce_n[0] ^ ce_n[1]));
	end
	initial begin
		done_out = 1'b0;
		wait (rst_in === 1'b0);
		foreach (edge_keys[i]) issue(1'b1, edge_keys[i]);
		foreach (edge_keys[i]) issue(1'b0, edge_keys[i]);
		drain();
		// reader stalled: two reads fill the buffer, four fill the queue
		stall = 1'b1;
		repeat (6) issue(1'b0, keys[0]);
		@(negedge ref_clk_in) req_valid <= 1'b0;
		repeat (30) @(negedge ref_clk_in);
		chk("req_ready full", 36'h0, 36'(req_ready));
		stall = 1'b0;
		// random mix, back to back, both banks
		repeat (150) begin
			if ($urandom % 2) issue(1'b1, 17'($urandom));
			else issue(1'b0, keys[$urandom % keys.size()]);
		end
		drain();
		done_out = 1'b1;
	end
endmodule

module ntsc_sram_ctrl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk_in = 1'b0;
	logic mem_clk_in = 1'b0;
	logic rst_in = 1'b1;
	int fails = 0;
	int checks = 0;
	int f0, f1, c0, c1;
	logic d0, d1;
	initial forever #20 ref_clk_in = ~ref_clk_in;
	// link clock, 125 ns, offset so its edges drift past the user clock's
	initial begin
		#7;
		forever #62.5 mem_clk_in = ~mem_clk_in;
	end
	ntsc_lane #(.PIPE(1'b1)) i_ntsc_lane_pipe (.ref_clk_in(ref_clk_in), .mem_clk_in(mem_clk_in),
		.rst_in(rst_in), .fails_out(f0), .checks_out(c0), .done_out(d0));
	ntsc_lane #(.PIPE(1'b0)) i_ntsc_lane_flow (.ref_clk_in(ref_clk_in), .mem_clk_in(mem_clk_in),
		.rst_in(rst_in), .fails_out(f1), .checks_out(c1), .done_out(d1));
	// sums both lanes, prints the verdict and ends the run
	task automatic report_and_stop();
		fails += f0 + f1;
		checks += c0 + c1;
		$display("mismatches %0d comparisons %0d", fails, checks);
		if (fails == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// reset spans five link cycles so the slow domain sees it too
	initial begin
		void'($urandom(35));
		repeat (5) @(posedge mem_clk_in);
		@(negedge ref_clk_in);
		rst_in = 1'b0;
		wait (d0 === 1'b1 && d1 === 1'b1);
		report_and_stop();
	end
	// watchdog, well past the expected run of a few tens of microseconds
	initial begin
		#2000000;
		fails++;
		report_and_stop();
	end
endmodule
